// file: logic/mafl_top.v
// alarm, flag, mask and lane control logic of a four-lane transceiver
//
// Function
// - alarm and warning thresholds are held for bias, temperature, tx power, rx power and supply.
// - a monitored value outside a threshold sets its flag and requests an interrupt.
// - per tx lane, input signal loss and transmitter fault each set a flag and request an interrupt.
// - per rx lane, optical input signal loss sets a flag and requests an interrupt.
// - every flag is latched and stays set after its cause goes away.
// - every source has a mask; a masked source still sets its flag but requests no interrupt.
// - the host clears the flags of a flag register only by reading that register.
// - a tx lane that loses its input is squelched unless tx squelch is disabled.
// - a tx lane is disabled on a fault on that lane or when the host deactivates it.
// - an rx lane output is squelched on optical loss unless rx squelch is disabled, and when deactivated.
// - there are four independent tx and four independent rx lanes, each with its own flags and controls.
// - lane status, alarm and warning flags and fault information are readable by the host.
// - thresholds are fixed factory values that define the normal range.
`timescale 1ns/1ps
`default_nettype none
`include "mafl_regs.vh"
module mafl_top #(
    parameter [15:0] HI_ALARM = `MAFL_HI_ALARM_DEF,
    parameter [15:0] HI_WARN = `MAFL_HI_WARN_DEF,
    parameter [15:0] LO_WARN = `MAFL_LO_WARN_DEF,
    parameter [15:0] LO_ALARM = `MAFL_LO_ALARM_DEF
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [79:0] i_mon_values,
    input wire [3:0] i_tx_input_signal_lost,
    input wire [3:0] i_tx_fault,
    input wire [3:0] i_rx_input_signal_lost,
    input wire [19:0] i_mon_mask,
    input wire [3:0] i_tx_sig_lost_mask,
    input wire [3:0] i_tx_fault_mask,
    input wire [3:0] i_rx_sig_lost_mask,
    input wire [3:0] i_tx_squelch_dis,
    input wire [3:0] i_rx_squelch_dis,
    input wire [3:0] i_tx_deactivate,
    input wire [3:0] i_rx_deactivate,
    input wire i_rd_stb,
    input wire [1:0] i_rd_sel,
    output reg [19:0] o_rd_data,
    output reg o_rd_valid,
    output reg o_int_n,
    output reg [3:0] o_tx_squelch,
    output reg [3:0] o_tx_disable,
    output reg [3:0] o_rx_squelch,
    output reg [3:0] o_tx_sig_lost_status,
    output reg [3:0] o_tx_fault_status,
    output reg [3:0] o_rx_sig_lost_status
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire [3:0] tx_lost_s;
    wire [3:0] tx_flt_s;
    wire [3:0] rx_lost_s;
    mafl_sync3 #(.W(12)) mafl_sync3_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_async({i_tx_input_signal_lost, i_tx_fault, i_rx_input_signal_lost}),
        .o_sync({tx_lost_s, tx_flt_s, rx_lost_s})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // helper functions
    // threshold compare: bits 3..0 = hi alarm, lo alarm, hi warn, lo warn
    function [3:0] mon_cmp;
        input [15:0] v;
        begin
            mon_cmp = {v > HI_ALARM, v < LO_ALARM, v > HI_WARN, v < LO_WARN};
        end
    endfunction

    // lane flag update, a new cause wins over a clear by read
    function [3:0] lane_flag_upd;
        input clr;
        input [3:0] old;
        input [3:0] cause;
        begin
            lane_flag_upd = (clr ? 4'h0 : old) | cause;
        end
    endfunction

    // read strobe aimed at one flag register
    function sel_hit;
        input stb;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_hit = stb && (sel == code);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // threshold compare, registered once
    reg [19:0] mon_cond;
    integer k;
    always @* begin
        mon_cond = 20'h00000;
        for (k = 0; k < `MAFL_NUM_MON; k = k + 1) begin
            mon_cond[k*4 +: 4] = mon_cmp(i_mon_values[k*16 +: 16]);
        end
    end

    reg [19:0] mon_cond_reg;
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mon_cond_reg <= `MAFL_FLAG_RESET;
        end else begin
            mon_cond_reg <= mon_cond;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // latched flags, cleared by a read of their register, set wins
    reg [19:0] mon_flag_reg;
    reg [19:0] mon_flag_next;
    reg [3:0] tx_lost_flag_reg;
    reg [3:0] tx_lost_flag_next;
    reg [3:0] tx_flt_flag_reg;
    reg [3:0] tx_flt_flag_next;
    reg [3:0] rx_lost_flag_reg;
    reg [3:0] rx_lost_flag_next;
    wire rd_mon;
    wire rd_tx;
    wire rd_rx;
    assign rd_mon = sel_hit(i_rd_stb, i_rd_sel, `MAFL_SEL_MON);
    assign rd_tx = sel_hit(i_rd_stb, i_rd_sel, `MAFL_SEL_TX);
    assign rd_rx = sel_hit(i_rd_stb, i_rd_sel, `MAFL_SEL_RX);

    always @* begin
        mon_flag_next = (rd_mon ? 20'h00000 : mon_flag_reg) | mon_cond_reg;
        tx_lost_flag_next = lane_flag_upd(rd_tx, tx_lost_flag_reg, tx_lost_s);
        tx_flt_flag_next = lane_flag_upd(rd_tx, tx_flt_flag_reg, tx_flt_s);
        rx_lost_flag_next = lane_flag_upd(rd_rx, rx_lost_flag_reg, rx_lost_s);
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mon_flag_reg <= `MAFL_FLAG_RESET;
            tx_lost_flag_reg <= `MAFL_LANE_RESET;
            tx_flt_flag_reg <= `MAFL_LANE_RESET;
            rx_lost_flag_reg <= `MAFL_LANE_RESET;
        end else begin
            mon_flag_reg <= mon_flag_next;
            tx_lost_flag_reg <= tx_lost_flag_next;
            tx_flt_flag_reg <= tx_flt_flag_next;
            rx_lost_flag_reg <= rx_lost_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port: returns register contents before the clear, held until the next read
    reg [19:0] rd_word;
    always @* begin
        case (i_rd_sel)
            `MAFL_SEL_MON: begin
                rd_word = mon_flag_reg;
            end
            `MAFL_SEL_TX: begin
                rd_word = {12'h000, tx_flt_flag_reg, tx_lost_flag_reg};
            end
            `MAFL_SEL_RX: begin
                rd_word = {16'h0000, rx_lost_flag_reg};
            end
            default: begin
                rd_word = 20'h00000;
            end
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_data <= 20'h00000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_stb;
            if (i_rd_stb) begin
                o_rd_data <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt, from next flag state so it follows the flags without lag
    wire int_mon;
    wire int_tx_lost;
    wire int_tx_flt;
    wire int_rx_lost;
    assign int_mon = |(mon_flag_next & ~i_mon_mask);
    assign int_tx_lost = |(tx_lost_flag_next & ~i_tx_sig_lost_mask);
    assign int_tx_flt = |(tx_flt_flag_next & ~i_tx_fault_mask);
    assign int_rx_lost = |(rx_lost_flag_next & ~i_rx_sig_lost_mask);
    wire int_any;
    assign int_any = int_mon | int_tx_lost | int_tx_flt | int_rx_lost;

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= ~int_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // lane control
    reg [3:0] tx_squelch_next;
    reg [3:0] tx_disable_next;
    reg [3:0] rx_squelch_next;
    always @* begin
        tx_squelch_next = tx_lost_s & ~i_tx_squelch_dis;
        tx_disable_next = tx_flt_s | i_tx_deactivate;
        rx_squelch_next = (rx_lost_s & ~i_rx_squelch_dis) | i_rx_deactivate;
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_tx_squelch <= `MAFL_LANE_RESET;
            o_tx_disable <= `MAFL_LANE_RESET;
            o_rx_squelch <= `MAFL_LANE_RESET;
        end else begin
            o_tx_squelch <= tx_squelch_next;
            o_tx_disable <= tx_disable_next;
            o_rx_squelch <= rx_squelch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // live lane status
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_tx_sig_lost_status <= `MAFL_LANE_RESET;
            o_tx_fault_status <= `MAFL_LANE_RESET;
            o_rx_sig_lost_status <= `MAFL_LANE_RESET;
        end else begin
            o_tx_sig_lost_status <= tx_lost_s;
            o_tx_fault_status <= tx_flt_s;
            o_rx_sig_lost_status <= rx_lost_s;
        end
    end
endmodule
`default_nettype wire

// file: logic/mafl_regs.vh
// constants for the module alarm and flag logic
`ifndef MAFL_REGS_VH
`define MAFL_REGS_VH
`define MAFL_NUM_LANES 4
`define MAFL_NUM_MON 5
`define MAFL_MON_WIDTH 16
`define MAFL_MON_BIAS 0
`define MAFL_MON_TEMP 1
`define MAFL_MON_TXPWR 2
`define MAFL_MON_RXPWR 3
`define MAFL_MON_VCC 4
`define MAFL_SEL_MON 2'h0
`define MAFL_SEL_TX 2'h1
`define MAFL_SEL_RX 2'h2
`define MAFL_FLAG_RESET 20'h00000
`define MAFL_LANE_RESET 4'h0
`define MAFL_MON_FLAG_WIDTH 20
`define MAFL_HI_ALARM_DEF 16'hf000
`define MAFL_HI_WARN_DEF 16'he000
`define MAFL_LO_WARN_DEF 16'h2000
`define MAFL_LO_ALARM_DEF 16'h1000
`endif

// file: logic/mafl_sync3.v
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module mafl_sync3 #(
    parameter W = 4
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_sync
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_sync <= (o_sync & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
        end
    end
endmodule
`default_nettype wire

// file: tb/mafl_top_properties.sv
// assertions on the alarm and flag logic ports
`timescale 1ns/1ps
`default_nettype none
module mafl_props (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_rd_stb,
    input wire logic [1:0] i_rd_sel,
    input wire logic [19:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_int_n,
    input wire logic [3:0] i_tx_deactivate,
    input wire logic [3:0] i_rx_deactivate,
    input wire logic [3:0] o_tx_disable,
    input wire logic [3:0] o_rx_squelch,
    input wire logic [3:0] o_tx_squelch,
    input wire logic [3:0] o_tx_sig_lost_status,
    input wire logic [3:0] i_tx_squelch_dis,
    input wire logic [3:0] i_tx_sig_lost_mask,
    input wire logic [19:0] i_mon_mask,
    input wire logic [3:0] i_tx_fault_mask,
    input wire logic [3:0] i_rx_sig_lost_mask
);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_rst_n);
sequence s_masked;
    (i_mon_mask == 20'hfffff
        && (i_tx_sig_lost_mask & i_tx_fault_mask & i_rx_sig_lost_mask) == 4'hf)[*3];
endsequence
sequence s_tx_lost;
    (o_tx_sig_lost_status != 4'h0 && $stable(o_tx_sig_lost_status)
        && i_tx_sig_lost_mask == 4'h0)[*2];
endsequence
AST_RD_VALID: assert property (i_rd_stb |=> o_rd_valid) else $error("no answer");
AST_NO_VALID: assert property (!i_rd_stb |=> !o_rd_valid) else $error("stray answer");
AST_RD_HOLD: assert property (!i_rd_stb |=> $stable(o_rd_data)) else $error("data moved");
AST_UNMAPPED: assert property (i_rd_stb && i_rd_sel == 2'h3 |=> o_rd_data == 20'h0)
    else $error("unmapped data");
AST_MASKED: assert property (s_masked |-> o_int_n) else $error("masked irq");
AST_INT_SET: assert property (s_tx_lost |-> !o_int_n) else $error("no irq");
AST_TX_SQ: assert property (s_tx_lost and (i_tx_squelch_dis == 4'h0)[*2]
    |-> (o_tx_squelch & o_tx_sig_lost_status) == o_tx_sig_lost_status)
    else $error("no tx squelch");
AST_TX_OFF: assert property ((i_tx_deactivate == 4'hf)[*8] |-> o_tx_disable == 4'hf)
    else $error("tx not off");
AST_RX_OFF: assert property ((i_rx_deactivate == 4'hf)[*8] |-> o_rx_squelch == 4'hf)
    else $error("rx not off");
endmodule
bind mafl_top mafl_props mafl_props_inst (.*);
`default_nettype wire

// file: tb/mafl_host.sv
// host controller model issuing flag register reads
`timescale 1ns/1ps
`default_nettype none
module mafl_host (
    input wire logic i_clk_sys,
    output logic o_rd_stb = 1'b0,
    output logic [1:0] o_rd_sel = 2'h3
);
// one strobe per read, flags cleared only this way
task automatic rd(input logic [1:0] sel);
    @(negedge i_clk_sys);
    o_rd_stb = 1'b1;
    o_rd_sel = sel;
    @(negedge i_clk_sys);
    o_rd_stb = 1'b0;
    o_rd_sel = ~sel;
endtask
endmodule
`default_nettype wire

// file: tb/mafl_top_tb_top.sv
// self-checking bench for the alarm and flag logic
`timescale 1ns/1ps
`default_nettype none
module mafl_top_tb_top;
logic i_clk_sys, i_rst_n, i_rd_stb, o_rd_valid, o_int_n;
logic [1:0] i_rd_sel;
logic [79:0] i_mon_values;
logic [19:0] i_mon_mask, o_rd_data;
logic [3:0] i_tx_input_signal_lost, i_tx_fault, i_rx_input_signal_lost, i_tx_sig_lost_mask;
logic [3:0] i_tx_fault_mask, i_rx_sig_lost_mask, i_tx_squelch_dis, i_rx_squelch_dis;
logic [3:0] i_tx_deactivate, i_rx_deactivate, o_tx_squelch, o_tx_disable, o_rx_squelch;
logic [3:0] o_tx_sig_lost_status, o_tx_fault_status, o_rx_sig_lost_status, pat;
logic [19:0] exp_q[$];
logic [31:0] seed = 32'h8e7e3287;
int errors = 0;
int n_checks = 0;
mafl_top mafl_top_inst (.*);
mafl_host mafl_host_inst (.i_clk_sys(i_clk_sys), .o_rd_stb(i_rd_stb), .o_rd_sel(i_rd_sel));
initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
end
task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
        errors++;
        $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
endtask
function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task automatic rd(input logic [1:0] sel, input logic [19:0] exp);
    exp_q.push_back(exp);
    mafl_host_inst.rd(sel);
endtask
always @(negedge i_clk_sys) begin
    if (o_rd_valid === 1'b1) begin
        if (exp_q.size() == 0) chk("rd_count", 20'h1, 20'h0);
        else chk("o_rd_data", o_rd_data, exp_q.pop_front());
    end
end
task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
initial begin
    i_rst_n = 1'b0;
    i_mon_values = {5{16'h8000}};
    {i_tx_input_signal_lost, i_tx_fault, i_rx_input_signal_lost} = 12'h0;
    {i_mon_mask, i_tx_sig_lost_mask, i_tx_fault_mask, i_rx_sig_lost_mask} = 32'h0;
    {i_tx_squelch_dis, i_rx_squelch_dis, i_tx_deactivate, i_rx_deactivate} = 16'h0;
    repeat (6) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk("o_int_n", {19'h0, o_int_n}, 20'h1);
    rd(2'h0, 20'h0);
    seed = lfsr(seed);
    pat = (seed[3:0] | 4'h1) & 4'h7;
    i_tx_input_signal_lost = pat;
    i_tx_fault = ~pat;
    repeat (8) @(negedge i_clk_sys);
    chk("o_int_n", {19'h0, o_int_n}, 20'h0);
    chk("o_tx_squelch", {16'h0, o_tx_squelch}, {16'h0, pat});
    chk("o_tx_disable", {16'h0, o_tx_disable}, {16'h0, ~pat});
    chk("o_tx_sig_lost_status", {16'h0, o_tx_sig_lost_status}, {16'h0, pat});
    chk("o_tx_fault_status", {16'h0, o_tx_fault_status}, {16'h0, ~pat});
    i_tx_squelch_dis = 4'h1;
    repeat (2) @(negedge i_clk_sys);
    chk("o_tx_squelch", {16'h0, o_tx_squelch}, {16'h0, pat & 4'he});
    {i_tx_input_signal_lost, i_tx_fault, i_tx_squelch_dis} = 12'h0;
    repeat (8) @(negedge i_clk_sys);
    chk("o_tx_disable", {16'h0, o_tx_disable}, 20'h0);
    rd(2'h1, {12'h0, ~pat, pat});
    rd(2'h1, 20'h0);
    chk("o_int_n", {19'h0, o_int_n}, 20'h1);
    $display("test tx lanes done");
    i_mon_values = {16'h0fff, 16'h8000, 16'h1000, 16'hf000, 16'hf001};
    repeat (4) @(negedge i_clk_sys);
    i_mon_values = {5{16'h8000}};
    rd(2'h0, 20'h5012a);
    rd(2'h0, 20'h0);
    $display("test monitors done");
    {i_mon_mask, i_tx_sig_lost_mask, i_tx_fault_mask, i_rx_sig_lost_mask} = {32{1'b1}};
    {i_tx_deactivate, i_rx_deactivate} = 8'hff;
    i_rx_input_signal_lost = pat;
    repeat (10) @(negedge i_clk_sys);
    chk("o_int_n", {19'h0, o_int_n}, 20'h1);
    chk("o_rx_squelch", {16'h0, o_rx_squelch}, 20'hf);
    chk("o_rx_sig_lost_status", {16'h0, o_rx_sig_lost_status}, {16'h0, pat});
    rd(2'h2, {16'h0, pat});
    rd(2'h3, 20'h0);
    i_rx_deactivate = 4'h0;
    repeat (2) @(negedge i_clk_sys);
    chk("o_rx_squelch", {16'h0, o_rx_squelch}, {16'h0, pat});
    i_rx_squelch_dis = 4'hf;
    repeat (3) @(negedge i_clk_sys);
    chk("o_rx_squelch", {16'h0, o_rx_squelch}, 20'h0);
    $display("test masks done");
    for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(negedge i_clk_sys);
    if (exp_q.size() != 0) errors++;
    print_verdict();
end
endmodule
`default_nettype wire
